// ===== soscr_pkg.sv
// Purpose: Constants for the supply, oscillator and sleep configuration bank
// Assumes: Byte-wide registers on a 32-bit Wishbone word per register
// Notes:   Printed offsets are register indices; byte address is four times the index
package soscr_pkg;

  // Register indices
  localparam logic [7:0] SOSCR_IDX_MON_CTRL  = 8'he3;
  localparam logic [7:0] SOSCR_IDX_CMP_STAT  = 8'he4;
  localparam logic [7:0] SOSCR_IDX_MAIN_TRIM = 8'he8;
  localparam logic [7:0] SOSCR_IDX_SLOW_TRIM = 8'he9;
  localparam logic [7:0] SOSCR_IDX_SLEEP_CFG = 8'heb;
  localparam logic [7:0] SOSCR_IDX_EXT_CFG   = 8'hec;
  localparam logic [7:0] SOSCR_IDX_IRQ_STAT  = 8'hf0;
  localparam logic [7:0] SOSCR_IDX_IRQ_EN    = 8'hf1;
  localparam logic [7:0] SOSCR_IDX_IRQ_CLR   = 8'hf2;

  // Writable masks (the comparator status mask is read-only), reserved bits read zero
  localparam logic [7:0] SOSCR_MSK_MON_CTRL  = 8'h3f;
  localparam logic [7:0] SOSCR_MSK_CMP_STAT  = 8'h02;
  localparam logic [7:0] SOSCR_MSK_SLOW_TRIM = 8'h6f;
  localparam logic [7:0] SOSCR_MSK_SLEEP_CFG = 8'hc0;
  localparam logic [7:0] SOSCR_MSK_EXT_CFG   = 8'h0c;
  localparam logic [7:0] SOSCR_MSK_IRQ       = 8'h03;

  // Reset values
  localparam logic [7:0] SOSCR_RST_MON_CTRL  = 8'h00;
  localparam logic [7:0] SOSCR_RST_MAIN_TRIM = 8'h00;
  localparam logic [7:0] SOSCR_RST_SLOW_TRIM = 8'h08;
  localparam logic [7:0] SOSCR_RST_SLEEP_CFG = 8'h00;
  localparam logic [7:0] SOSCR_RST_EXT_CFG   = 8'h00;

  // Field positions
  localparam int SOSCR_POS_BROWN_LVL  = 0;
  localparam int SOSCR_POS_SPEED_RST  = 3;
  localparam int SOSCR_POS_RESET_LVL  = 4;
  localparam int SOSCR_POS_CMP_FLAG   = 1;
  localparam int SOSCR_POS_SLOW_TRIM  = 0;
  localparam int SOSCR_POS_SLOW_FREQ  = 5;
  localparam int SOSCR_POS_SLOW_PD    = 6;
  localparam int SOSCR_POS_DUTY_SEL   = 6;
  localparam int SOSCR_POS_DUTY_EXT   = 2;
  localparam int SOSCR_POS_IRQ_BROWN  = 0;
  localparam int SOSCR_POS_IRQ_PHASE  = 1;

  // Duty ratios as log2 of the period in 32.768 kHz ticks
  localparam logic [3:0] SOSCR_LOG_DUTY_00 = 4'h8;
  localparam logic [3:0] SOSCR_LOG_DUTY_01 = 4'ha;
  localparam logic [3:0] SOSCR_LOG_DUTY_10 = 4'h6;
  localparam logic [3:0] SOSCR_LOG_DUTY_11 = 4'h4;
  localparam logic [3:0] SOSCR_LOG_EXT_01  = 4'hf;
  localparam logic [3:0] SOSCR_LOG_EXT_10  = 4'hd;

  // Slow tick from the 100 MHz system clock
  localparam int SOSCR_CLK_HZ       = 100_000_000;
  localparam int SOSCR_TICK_HZ      = 32_768;
  localparam int SOSCR_TICK_CYCLES  = SOSCR_CLK_HZ / SOSCR_TICK_HZ;

  typedef enum logic [1:0] {SOSCR_ST_IDLE, SOSCR_ST_ACK} soscr_bus_e;

endpackage

// ===== soscr_duty_gen.sv
// Purpose: Sleep duty-cycle generator for the supply monitor, bandgap and pump
// Assumes: One-cycle tick enable at the 32.768 kHz rate
// Notes:   On phase is one tick per period of 2**log_period ticks
`timescale 1ns/1ns
module soscr_duty_gen #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  // Control
  input  wire logic             tick_in,
  input  wire logic [3:0]       log_period_in,
  // Outputs
  output logic                  on_out,
  output logic                  period_start_out
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last_w;
  logic             wrap_w;

  assign last_w           = CNT_W'((32'h1 << log_period_in) - 32'h1);
  assign wrap_w           = tick_in && (cnt_q >= last_w);
  assign period_start_out = wrap_w;

  // Ratio kept in ticks
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_q  <= '0;
      on_out <= 1'b0;
    end else if (tick_in) begin
      cnt_q  <= wrap_w ? '0 : cnt_q + 1'b1;
      on_out <= wrap_w;
    end
  end

endmodule // soscr_duty_gen

// ===== soscr_regs.sv
// Purpose: Supply monitor, oscillator trim and sleep duty configuration bank
// Assumes: Classic Wishbone slave, 32-bit words, byte data in bits 7:0
// Notes:   Ack comes one cycle after the request is seen; unmapped reads give zero
// What this block does
// [RULE_01] Three-bit brownout level picks eight thresholds
// [RULE_02] Brownout resets speed select when enabled
// [RULE_03] Reset trip level forwarded to monitor
// [RULE_04] Status bit one mirrors brownout comparator
// [RULE_05] Main trim drives oscillator, boot loads
// [RULE_06] Going faster: write trim, then range
// [RULE_07] Going slower: change range, then trim
// [RULE_08] Firmware leaves main trim otherwise alone
// [RULE_09] Bit six selects slow-osc powerdown style
// [RULE_10] Bit five selects 32 kHz or 1 kHz
// [RULE_11] Firmware keeps slow trim factory value
// [RULE_12] Duty code selects 1/256,1/1024,1/64,1/16
// [RULE_13] Duty counted in 32.768 kHz periods
// [RULE_14] Software writes zeros to reserved bits
// [RULE_15] Extension code zero follows duty field
// [RULE_16] Reads return fields, reserved as zero
`timescale 1ns/1ns
module soscr_regs
  import soscr_pkg::*;
#(
  parameter int          ADR_W     = 10,
  parameter logic [7:0]  BOOT_TRIM = 8'h80
) (
  // Clock and reset
  input  wire logic              MCLK_IN,
  input  wire logic              RST_B_IN,
  // Wishbone slave
  input  wire logic              WB_CYC_IN,
  input  wire logic              WB_STB_IN,
  input  wire logic              WB_WE_IN,
  input  wire logic [ADR_W-1:0]  WB_ADR_IN,
  input  wire logic [3:0]        WB_SEL_IN,
  input  wire logic [31:0]       WB_DAT_IN,
  output logic [31:0]            WB_DAT_OUT,
  output logic                   WB_ACK_OUT,
  // Analog side
  input  wire logic              BROWNOUT_CMP_IN,
  input  wire logic              BOOT_LOAD_IN,
  output logic [2:0]             BROWNOUT_TRIP_LEVEL_OUT,
  output logic [1:0]             RESET_TRIP_LEVEL_OUT,
  output logic                   SPEED_SELECT_RESET_OUT,
  output logic [7:0]             MAIN_OSC_TRIM_OUT,
  output logic                   SLOW_OSC_POWERDOWN_SELECT_OUT,
  output logic                   SLOW_OSC_FREQUENCY_SELECT_OUT,
  output logic [3:0]             SLOW_OSC_TRIM_OUT,
  output logic                   MONITOR_POWER_ON_OUT,
  // Interrupt
  output logic                   IRQ_OUT
);

  logic [7:0] mon_ctrl_q;
  logic [7:0] main_trim_q;
  logic [7:0] slow_trim_q;
  logic [7:0] sleep_cfg_q;
  logic [7:0] ext_cfg_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_stat_d;
  logic [7:0] irq_en_q;
  logic       cmp_q;
  logic       cmp_prev_q;
  logic       ack_q;
  logic [31:0] rdat_q;
  logic [15:0] div_q;
  logic        tick_w;
  logic        phase_on_w;
  logic        period_w;
  soscr_bus_e  bus_q;

  // Bus decode
  logic        req_w;
  logic        wr_w;
  logic        lane0_w;
  logic [7:0]  idx_w;
  logic        idx_ok_w;
  logic [7:0]  wbyte_w;
  logic [7:0]  rbyte_w;
  logic [7:0]  cmp_stat_w;
  logic [3:0]  log_base_w;
  logic [3:0]  log_period_w;
  logic [1:0]  ext_w;
  logic [7:0]  events_w;
  logic        brown_rise_w;

  assign req_w    = WB_CYC_IN && WB_STB_IN && (bus_q == SOSCR_ST_IDLE);
  // Compare in 32 bits so the 256-entry limit is not cut to eight bits
  assign idx_ok_w = (WB_ADR_IN[1:0] == 2'h0) && ((32'(WB_ADR_IN) >> 2) < 32'h100);
  assign idx_w    = 8'(WB_ADR_IN[ADR_W-1:2]);
  assign lane0_w  = WB_SEL_IN[0];
  assign wr_w     = req_w && WB_WE_IN && lane0_w && idx_ok_w;
  assign wbyte_w  = WB_DAT_IN[7:0];

  // [RULE_04] comparator status bit
  assign cmp_stat_w = 8'(cmp_q) << SOSCR_POS_CMP_FLAG;

  // [RULE_16] readback with reserved zero
  assign rbyte_w =
    !idx_ok_w                       ? 8'h00 :
    (idx_w == SOSCR_IDX_MON_CTRL)  ? (mon_ctrl_q  & SOSCR_MSK_MON_CTRL)  :
    (idx_w == SOSCR_IDX_CMP_STAT)  ? (cmp_stat_w  & SOSCR_MSK_CMP_STAT)  :
    (idx_w == SOSCR_IDX_MAIN_TRIM) ? main_trim_q :
    (idx_w == SOSCR_IDX_SLOW_TRIM) ? (slow_trim_q & SOSCR_MSK_SLOW_TRIM) :
    (idx_w == SOSCR_IDX_SLEEP_CFG) ? (sleep_cfg_q & SOSCR_MSK_SLEEP_CFG) :
    (idx_w == SOSCR_IDX_EXT_CFG)   ? (ext_cfg_q   & SOSCR_MSK_EXT_CFG)   :
    (idx_w == SOSCR_IDX_IRQ_STAT)  ? irq_stat_q :
    (idx_w == SOSCR_IDX_IRQ_EN)    ? irq_en_q : 8'h00;

  // Bus handshake: single-cycle wait, ack for one cycle
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      bus_q  <= SOSCR_ST_IDLE;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      unique case (bus_q)
        SOSCR_ST_IDLE: begin
          ack_q <= req_w;
          if (req_w) begin
            bus_q  <= SOSCR_ST_ACK;
            rdat_q <= {24'h0, rbyte_w};
          end
        end
        SOSCR_ST_ACK: begin
          ack_q <= 1'b0;
          bus_q <= SOSCR_ST_IDLE;
        end
      endcase
    end
  end

  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = rdat_q;

  // Configuration writes; masks keep reserved bits at zero even if written
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      mon_ctrl_q  <= SOSCR_RST_MON_CTRL;
      main_trim_q <= SOSCR_RST_MAIN_TRIM;
      slow_trim_q <= SOSCR_RST_SLOW_TRIM;
      sleep_cfg_q <= SOSCR_RST_SLEEP_CFG;
      ext_cfg_q   <= SOSCR_RST_EXT_CFG;
      irq_en_q    <= 8'h00;
    end else begin
      // [RULE_05] factory trim at boot
      if (BOOT_LOAD_IN) begin
        main_trim_q <= BOOT_TRIM;
      end else if (wr_w && idx_w == SOSCR_IDX_MAIN_TRIM) begin
        main_trim_q <= wbyte_w;
      end
      // [RULE_16] synchronous field writes
      if (wr_w && idx_w == SOSCR_IDX_MON_CTRL) begin
        mon_ctrl_q <= wbyte_w & SOSCR_MSK_MON_CTRL;
      end
      if (wr_w && idx_w == SOSCR_IDX_SLOW_TRIM) begin
        slow_trim_q <= wbyte_w & SOSCR_MSK_SLOW_TRIM;
      end
      if (wr_w && idx_w == SOSCR_IDX_SLEEP_CFG) begin
        sleep_cfg_q <= wbyte_w & SOSCR_MSK_SLEEP_CFG;
      end
      if (wr_w && idx_w == SOSCR_IDX_EXT_CFG) begin
        ext_cfg_q <= wbyte_w & SOSCR_MSK_EXT_CFG;
      end
      if (wr_w && idx_w == SOSCR_IDX_IRQ_EN) begin
        irq_en_q <= wbyte_w & SOSCR_MSK_IRQ;
      end
    end
  end

  // Comparator is taken as synchronous; one stage aligns status and edge detect
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      cmp_q      <= 1'b0;
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_q      <= BROWNOUT_CMP_IN;
      cmp_prev_q <= cmp_q;
    end
  end

  // [RULE_01] level field to monitor, 000 lowest
  assign BROWNOUT_TRIP_LEVEL_OUT = mon_ctrl_q[SOSCR_POS_BROWN_LVL +: 3];
  // [RULE_03] reset level forwarded
  assign RESET_TRIP_LEVEL_OUT    = mon_ctrl_q[SOSCR_POS_RESET_LVL +: 2];
  // [RULE_02] gated speed reset
  assign SPEED_SELECT_RESET_OUT  = cmp_q && mon_ctrl_q[SOSCR_POS_SPEED_RST];

  // [RULE_05] trim drives oscillator
  assign MAIN_OSC_TRIM_OUT = main_trim_q;
  // [RULE_09] powerdown style select
  assign SLOW_OSC_POWERDOWN_SELECT_OUT = slow_trim_q[SOSCR_POS_SLOW_PD];
  // [RULE_10] frequency select
  assign SLOW_OSC_FREQUENCY_SELECT_OUT = slow_trim_q[SOSCR_POS_SLOW_FREQ];
  // [RULE_11] factory trim forwarded
  assign SLOW_OSC_TRIM_OUT = slow_trim_q[SOSCR_POS_SLOW_TRIM +: 4];

  // [RULE_13] 32.768 kHz tick divider
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      div_q <= 16'h0;
    end else begin
      div_q <= tick_w ? 16'h0 : div_q + 16'h1;
    end
  end
  assign tick_w = (div_q == 16'(SOSCR_TICK_CYCLES - 1));

  // [RULE_12] duty code decode
  assign log_base_w =
    (sleep_cfg_q[SOSCR_POS_DUTY_SEL +: 2] == 2'h0) ? SOSCR_LOG_DUTY_00 :
    (sleep_cfg_q[SOSCR_POS_DUTY_SEL +: 2] == 2'h1) ? SOSCR_LOG_DUTY_01 :
    (sleep_cfg_q[SOSCR_POS_DUTY_SEL +: 2] == 2'h2) ? SOSCR_LOG_DUTY_10 : SOSCR_LOG_DUTY_11;

  // [RULE_15] extension overrides; reserved code falls back to the duty field
  assign ext_w        = ext_cfg_q[SOSCR_POS_DUTY_EXT +: 2];
  assign log_period_w = (ext_w == 2'h1) ? SOSCR_LOG_EXT_01 :
                        (ext_w == 2'h2) ? SOSCR_LOG_EXT_10 : log_base_w;

  // [RULE_13] gate monitor, bandgap and pump
  soscr_duty_gen #(
    .CNT_W (16)
  ) u_duty (
    .clk_in           (MCLK_IN),
    .rst_b_in         (RST_B_IN),
    .tick_in          (tick_w),
    .log_period_in    (log_period_w),
    .on_out           (phase_on_w),
    .period_start_out (period_w)
  );
  assign MONITOR_POWER_ON_OUT = phase_on_w;

  // Events: brownout comparator rising, start of each duty period
  assign brown_rise_w = cmp_q && !cmp_prev_q;
  assign events_w     = (8'(brown_rise_w) << SOSCR_POS_IRQ_BROWN) |
                        (8'(period_w)     << SOSCR_POS_IRQ_PHASE);

  // Set wins over a clear in the same cycle
  assign irq_stat_d = (irq_stat_q &
                       ~((wr_w && idx_w == SOSCR_IDX_IRQ_CLR) ? wbyte_w : 8'h00)) | events_w;

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      irq_stat_q <= 8'h00;
    end else begin
      irq_stat_q <= irq_stat_d & SOSCR_MSK_IRQ;
    end
  end

  assign IRQ_OUT = |(irq_stat_q & irq_en_q);

endmodule // soscr_regs

// ===== soscr_regs_assertions.sv
// Purpose: Port-level assertions for the configuration bank
// Assumes: Sees only the ports of soscr_regs
// Notes:   Monitor pulse width is counted in helper logic
`timescale 1ns/1ns
module soscr_regs_chk
  import soscr_pkg::*;
#(
  parameter int         ADR_W     = 10,
  parameter logic [7:0] BOOT_TRIM = 8'h80
) (
  // Clock, reset and bus
  input wire logic             MCLK_IN,
  input wire logic             RST_B_IN,
  input wire logic             WB_CYC_IN,
  input wire logic             WB_STB_IN,
  input wire logic             WB_WE_IN,
  input wire logic [ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0]       WB_SEL_IN,
  input wire logic [31:0]      WB_DAT_IN,
  input wire logic [31:0]      WB_DAT_OUT,
  input wire logic             WB_ACK_OUT,
  // Analog side
  input wire logic             BROWNOUT_CMP_IN,
  input wire logic             BOOT_LOAD_IN,
  input wire logic [2:0]       BROWNOUT_TRIP_LEVEL_OUT,
  input wire logic [1:0]       RESET_TRIP_LEVEL_OUT,
  input wire logic             SPEED_SELECT_RESET_OUT,
  input wire logic [7:0]       MAIN_OSC_TRIM_OUT,
  input wire logic             MONITOR_POWER_ON_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);
  logic [11:0] on_cnt_q;
  wire logic req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  wire logic wr_ctrl = req && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == ADR_W'(4 * SOSCR_IDX_MON_CTRL);
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN || !MONITOR_POWER_ON_OUT) on_cnt_q <= '0;
    else on_cnt_q <= on_cnt_q + 12'h001;
  end
  property p_ack_next; req |=> WB_ACK_OUT; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause; WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_upper_zero; WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h000000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper data");
  property p_levels;
    wr_ctrl |=> {RESET_TRIP_LEVEL_OUT, BROWNOUT_TRIP_LEVEL_OUT} == {$past(WB_DAT_IN[5:4]), $past(WB_DAT_IN[2:0])};
  endproperty
  a_levels: assert property (p_levels) else $error("trip levels");
  property p_speed; SPEED_SELECT_RESET_OUT |-> $past(BROWNOUT_CMP_IN); endproperty
  a_speed: assert property (p_speed) else $error("speed reset");
  property p_boot; BOOT_LOAD_IN |=> MAIN_OSC_TRIM_OUT == BOOT_TRIM; endproperty
  a_boot: assert property (p_boot) else $error("boot trim");
  property p_on_width; $fell(MONITOR_POWER_ON_OUT) |-> on_cnt_q == SOSCR_TICK_CYCLES; endproperty
  a_on_width: assert property (p_on_width) else $error("on width");
endmodule // soscr_regs_chk
bind soscr_regs soscr_regs_chk #(.ADR_W(ADR_W), .BOOT_TRIM(BOOT_TRIM)) i_soscr_regs_chk (
  .MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
  .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .BROWNOUT_CMP_IN(BROWNOUT_CMP_IN),
  .BOOT_LOAD_IN(BOOT_LOAD_IN), .BROWNOUT_TRIP_LEVEL_OUT(BROWNOUT_TRIP_LEVEL_OUT),
  .RESET_TRIP_LEVEL_OUT(RESET_TRIP_LEVEL_OUT), .SPEED_SELECT_RESET_OUT(SPEED_SELECT_RESET_OUT),
  .MAIN_OSC_TRIM_OUT(MAIN_OSC_TRIM_OUT), .MONITOR_POWER_ON_OUT(MONITOR_POWER_ON_OUT));

// ===== tb_soscr_regs.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Classic Wishbone, ack one cycle after request
// Notes:   Duty check uses code 11, one full period
`timescale 1ns/1ns
module tb_soscr_regs
  import soscr_pkg::*;
;
  // Boot trim value is arbitrary
  localparam logic [7:0] BOOT = 8'h5a;
  logic        clk, rst_b, cyc, stb, we, cmp, boot;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [7:0]  sh [256];
  wire logic [31:0] dout;
  wire logic   ack, spd, slpd, slfq, mon, irq;
  wire logic [2:0] blvl;
  wire logic [1:0] rlvl;
  wire logic [7:0] mtrim;
  wire logic [3:0] strim;
  int n_fail, check_count, n;
  soscr_regs #(.ADR_W(10), .BOOT_TRIM(BOOT)) i_soscr_regs (
    .MCLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
    .BROWNOUT_CMP_IN(cmp), .BOOT_LOAD_IN(boot), .BROWNOUT_TRIP_LEVEL_OUT(blvl),
    .RESET_TRIP_LEVEL_OUT(rlvl), .SPEED_SELECT_RESET_OUT(spd), .MAIN_OSC_TRIM_OUT(mtrim),
    .SLOW_OSC_POWERDOWN_SELECT_OUT(slpd), .SLOW_OSC_FREQUENCY_SELECT_OUT(slfq),
    .SLOW_OSC_TRIM_OUT(strim), .MONITOR_POWER_ON_OUT(mon), .IRQ_OUT(irq));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    $display("Checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s0);
    int k;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= {3'b000, s0};
    wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    rdat = dout;
    cyc <= 0;
    stb <= 0;
  endtask
  function automatic logic [7:0] msk(input logic [7:0] idx);
    case (idx)
      8'he3: msk = 8'h3f;
      8'he8: msk = 8'hff;
      8'he9: msk = 8'h6f;
      8'heb: msk = 8'hc0;
      default: msk = 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 1'b1);
    sh[idx] = d & msk(idx);
  endtask
  task automatic ports();
    chk({blvl, rlvl, mtrim, slpd, slfq, strim}, {sh[8'he3][2:0], sh[8'he3][5:4], sh[8'he8],
        sh[8'he9][6:5], sh[8'he9][3:0]});
  endtask
  logic [7:0] ix [5] = '{8'he3, 8'he4, 8'he8, 8'he9, 8'heb};
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
  initial begin
    void'($urandom(32'h831881ad));
    {rst_b, cyc, stb, we, cmp, boot, adr, sel, wdat} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1;
    foreach (ix[i]) begin
      wb(1'b0, ix[i], 8'h00, 1'b1);
      chk(rdat, rv[i]);
      sh[ix[i]] = rv[i];
    end
    $display("Test reset values done");
    // trim writes stand for range-change loads
    repeat (8) foreach (ix[i]) begin
      wr(ix[i], 8'($urandom) & msk(ix[i]));
      wb(1'b0, ix[i], 8'h00, 1'b1);
      chk(rdat, sh[ix[i]]);
      ports();
    end
    wb(1'b1, 8'he3, 8'h3f, 1'b0);
    wb(1'b0, 8'he3, 8'h00, 1'b1);
    chk(rdat, sh[8'he3]);
    wb(1'b0, 8'he0, 8'h00, 1'b1);
    chk(rdat, 32'h0);
    $display("Test random access done");
    wr(8'he3, 8'h08);
    wr(8'hf2, 8'h03);
    wr(8'hf1, 8'h01);
    cmp <= 1;
    repeat (3) @(posedge clk);
    chk(spd, 1'b1);
    chk(irq, 1'b1);
    wb(1'b0, 8'he4, 8'h00, 1'b1);
    chk(rdat, 32'h2);
    wr(8'he3, 8'h00);
    chk(spd, 1'b0);
    wr(8'hf1, 8'h00);
    chk(irq, 1'b0);
    wr(8'hf2, 8'h01);
    wr(8'hf1, 8'h01);
    chk(irq, 1'b0);
    cmp <= 0;
    $display("Test comparator and interrupt done");
    @(posedge clk) boot <= 1;
    @(posedge clk) boot <= 0;
    @(posedge clk);
    chk(mtrim, BOOT);
    wr(8'hf1, 8'h02);
    wr(8'heb, 8'hc0);
    wr(8'hf2, 8'h02);
    chk(irq, 1'b0);
    n = 0;
    while (mon !== 1'b1 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (mon === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(n, SOSCR_TICK_CYCLES);
    n = 0;
    while (mon !== 1'b1 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    chk(n, 15 * SOSCR_TICK_CYCLES);
    chk(irq, 1'b1);
    $display("Test duty cycle done");
    stop_test();
  end
  initial begin
    repeat (99000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule // tb_soscr_regs
